/* hw/decd_bits.sv */
`timescale 1ns/100ps
`include "decd_regs.svh"

module decd_bits #(
   parameter int W  = 16,
   parameter int PW = $clog2(W + 1)
) (
   input  wire logic [W-1:0]  i_a,
   input  wire logic [W-1:0]  i_b,
   output logic      [PW-1:0] o_popcnt,
   output logic      [W-1:0]  o_rev_word,
   output logic      [W-1:0]  o_rev_nbits
);

   // ============================================================
   // Bit reversal is used for both the full and the partial forms.
   function automatic logic [W-1:0] rev(input logic [W-1:0] x);
      logic [W-1:0] r;
      r = '0;
      for (int i = 0; i < W; i++) begin
         r[i] = x[W-1-i];
      end
      return r;
   endfunction

   function automatic logic [PW-1:0] pop(input logic [W-1:0] x);
      logic [PW-1:0] n;
      n = '0;
      for (int i = 0; i < W; i++) begin
         n = n + PW'(x[i]);
      end
      return n;
   endfunction

   wire logic        n_big   = (i_a >= W[W-1:0]);
   wire logic [W-1:0] shamt  = W[W-1:0] - i_a;

   assign o_popcnt    = pop(i_a);
   assign o_rev_word  = rev(i_a);
   // Counts of the word width or more reverse the whole word.
   assign o_rev_nbits = n_big ? rev(i_b) : (rev(i_b) >> shamt);

endmodule // decd_bits

/* hw/decd_core.sv */
// ============================================================
// Overview of operation
// - Test error pushes inverse, clears; 2/3 cycles.
// - Stop on error: 2 cycles, deschedules if set.
// - Zero-based index check: 2 cycles, flags range.
// - Breakpoint off: zero-offset jump costs 3 cycles.
// - Breakpoint on, high priority: 11 cycles.
// - Breakpoint on, low priority: 13 cycles.
// - Disarm breakpoint flag in 1 cycle.
// - Arm breakpoint flag in 1 cycle.
// - Query breakpoint flag, 2 cycles.
// - Disable high priority timer interrupt, 1 cycle.
// - Disable low priority timer interrupt, 1 cycle.
// - Enable high priority timer interrupt, 6 cycles.
// - Enable low priority timer interrupt, 6 cycles.
// - Word CRC step takes 35 cycles.
// - Byte CRC step takes 11 cycles.
// - Bit count costs set bits plus two.
// - Full word bit reversal, 36 cycles.
// - Reverse lowest n bits, n plus four.
// - Breakpoint off: jump is no-op, may deschedule.
// - Breakpoint never deschedules, keeps registers.
`timescale 1ns/100ps
`include "decd_regs.svh"

module decd_core
   import decd_pkg::*;
#(
   parameter int W  = 16,
   parameter int CW = 17
) (
   input  wire logic         i_clk,
   input  wire logic         i_rstn,
   input  wire logic         i_ce,
   input  wire logic         i_instr_valid,
   input  wire logic [7:0]   i_instr_byte,
   input  wire logic [W-1:0] i_areg,
   input  wire logic [W-1:0] i_breg,
   input  wire logic [W-1:0] i_creg,
   input  wire logic         i_high_pri,
   input  wire logic         i_slice_due,
   input  wire logic [1:0]   i_addr,
   input  wire logic [W-1:0] i_wdata,
   input  wire logic         i_wr,
   input  wire logic         i_rd,
   output logic              o_ready,
   output logic              o_done,
   output logic [W-1:0]      o_result,
   output logic              o_result_wr,
   output logic              o_other,
   output logic              o_desched,
   output logic              o_break,
   output logic              o_error,
   output logic              o_brk_en,
   output logic              o_timer_hi_en,
   output logic              o_timer_lo_en,
   output logic [W-1:0]      o_rdata
);

   localparam int PW = $clog2(W + 1);

   // ============================================================
   // State.
   decd_state_t    state_r,     state_nxt;
   logic [W-1:0]   oreg_r,      oreg_nxt;
   logic [W-1:0]   op_r,        op_nxt;
   logic           j0_r,        j0_nxt;
   logic [CW-1:0]  cnt_r,       cnt_nxt;
   logic [CW-1:0]  cost_r,      cost_nxt;
   logic [W-1:0]   pend_r,      pend_nxt;
   logic           fail_r,      fail_nxt;
   logic           ready_r,     ready_nxt;
   logic           done_r,      done_nxt;
   logic [W-1:0]   result_r,    result_nxt;
   logic           wr_r,        wr_nxt;
   logic           other_r,     other_nxt;
   logic           desched_r,   desched_nxt;
   logic           break_r,     break_nxt;
   logic           err_r,       err_nxt;
   logic           brk_r,       brk_nxt;
   logic           thi_r,       thi_nxt;
   logic           tlo_r,       tlo_nxt;
   logic [W-1:0]   rdata_r,     rdata_nxt;

   // ============================================================
   // Arithmetic units, fed straight from the operand inputs.
   logic [W-1:0]   crc_word;
   logic [W-1:0]   crc_byte;
   logic [PW-1:0]  popcnt;
   logic [W-1:0]   rev_word;
   logic [W-1:0]   rev_nbits;

   decd_crc #(.W(W)) u_crc (
      .i_data     (i_areg),
      .i_crc      (i_breg),
      .i_poly     (i_creg),
      .o_crc_word (crc_word),
      .o_crc_byte (crc_byte)
   );

   decd_bits #(.W(W), .PW(PW)) u_bits (
      .i_a         (i_areg),
      .i_b         (i_breg),
      .o_popcnt    (popcnt),
      .o_rev_word  (rev_word),
      .o_rev_nbits (rev_nbits)
   );

   // ============================================================
   // Decode of the incoming byte.
   wire logic [3:0]   fn       = i_instr_byte[7:4];
   wire logic [3:0]   dn       = i_instr_byte[3:0];
   wire logic [W-1:0] oper     = oreg_r | {{(W-4){1'b0}}, dn};
   wire logic         take     = (state_r == s_idle) && i_instr_valid;
   wire logic         is_j0    = (fn == `DECD_FN_JUMP) && (oper == '0);
   wire logic         is_opr   = (fn == `DECD_FN_OPR);
   wire logic [CW-1:0] popc_w  = CW'(popcnt);
   wire logic [CW-1:0] n_w     = CW'(i_areg);
   wire logic         csub_bad = (i_breg >= i_areg);
   wire logic         ccnt_bad = (i_breg == '0) || (i_breg > i_areg);
   wire logic         bus_err_clr = i_wr && (i_addr == `DECD_ADDR_STAT) &&
                                    i_wdata[`DECD_STAT_ERR];

   // ============================================================
   // Cost of an accepted operation; zero marks a code this block
   // does not execute, which is handed back to the rest of the core.
   function automatic logic [CW-1:0] op_cost(input logic [W-1:0] op,
                                             input logic         err,
                                             input logic         brk,
                                             input logic         hi);
      logic [CW-1:0] c;
      c = '0;
      unique case (op)
         `DECD_OP_TESTERR: c = err ? `DECD_C_TESTERR_ERR
                                   : `DECD_C_TESTERR_OK;
         `DECD_OP_STOPERR: c = `DECD_C_STOPERR;
         `DECD_OP_ZERO_BASED_INDEX_CHECK:   c = `DECD_C_ZERO_BASED_INDEX_CHECK;
         `DECD_OP_ONE_BASED_COUNT_CHECK:   c = `DECD_C_ONE_BASED_COUNT_CHECK;
         `DECD_OP_SETERR:  c = `DECD_C_SETERR;
         `DECD_OP_BREAK:   c = hi ? `DECD_C_BREAK_HI : `DECD_C_BREAK_LO;
         `DECD_OP_CLRBRK:  c = `DECD_C_BRKFLAG;
         `DECD_OP_SETBRK:  c = `DECD_C_BRKFLAG;
         `DECD_OP_TESTBRK: c = `DECD_C_TESTBRK;
         `DECD_OP_TDISH:   c = `DECD_C_TDIS;
         `DECD_OP_TDISL:   c = `DECD_C_TDIS;
         `DECD_OP_TENH:    c = `DECD_C_TEN;
         `DECD_OP_TENL:    c = `DECD_C_TEN;
         `DECD_OP_CRCW:    c = `DECD_C_CRCW;
         `DECD_OP_CRCB:    c = `DECD_C_CRCB;
         `DECD_OP_BITCNT:  c = popc_w + `DECD_C_BITCNT_ADD;
         `DECD_OP_REVW:    c = `DECD_C_REVW;
         `DECD_OP_REVN:    c = n_w + `DECD_C_REVN_ADD;
         default:          c = '0;
      endcase
      return c;
   endfunction

   wire logic [CW-1:0] j0_cost  = !brk_r     ? `DECD_C_J0 :
                                  i_high_pri ? `DECD_C_J0_BRK_HI :
                                               `DECD_C_J0_BRK_LO;
   wire logic [CW-1:0] opr_cost = op_cost(oper, err_r, brk_r, i_high_pri);
   wire logic [CW-1:0] acc_cost = is_j0 ? j0_cost : opr_cost;
   wire logic          acc_ours = is_j0 || (is_opr && (opr_cost != '0));

   // Result of the operation, computed at acceptance so that the
   // operand registers of the core may move on during execution.
   wire logic [W-1:0] acc_pend =
      (oper == `DECD_OP_CRCW)   ? crc_word  :
      (oper == `DECD_OP_CRCB)   ? crc_byte  :
      (oper == `DECD_OP_BITCNT) ? W'(popcnt) :
      (oper == `DECD_OP_REVW)   ? rev_word  :
      (oper == `DECD_OP_REVN)   ? rev_nbits : i_breg;

   wire logic acc_fail = (oper == `DECD_OP_ZERO_BASED_INDEX_CHECK) ? csub_bad :
                         (oper == `DECD_OP_ONE_BASED_COUNT_CHECK) ? ccnt_bad : 1'b0;

   wire logic [W-1:0] rd_mux =
      (i_addr == `DECD_ADDR_CTRL) ? W'({tlo_r, thi_r, brk_r}) :
      (i_addr == `DECD_ADDR_STAT) ? W'({~ready_r, err_r}) :
      (i_addr == `DECD_ADDR_LAST) ? op_r : cost_r[W-1:0];

   // ============================================================
   // Next-state logic.
   always_comb begin
      state_nxt   = state_r;
      oreg_nxt    = oreg_r;
      op_nxt      = op_r;
      j0_nxt      = j0_r;
      cnt_nxt     = cnt_r;
      cost_nxt    = cost_r;
      pend_nxt    = pend_r;
      fail_nxt    = fail_r;
      ready_nxt   = ready_r;
      done_nxt    = 1'b0;
      result_nxt  = result_r;
      wr_nxt      = 1'b0;
      other_nxt   = 1'b0;
      desched_nxt = 1'b0;
      break_nxt   = 1'b0;
      err_nxt     = err_r;
      brk_nxt     = brk_r;
      thi_nxt     = thi_r;
      tlo_nxt     = tlo_r;
      rdata_nxt   = i_rd ? rd_mux : '0;

      // Software writes come first so that an instruction finishing
      // in the same cycle overrides them.
      if (i_wr && (i_addr == `DECD_ADDR_CTRL)) begin
         brk_nxt = i_wdata[`DECD_CTRL_BRK];
         thi_nxt = i_wdata[`DECD_CTRL_THI];
         tlo_nxt = i_wdata[`DECD_CTRL_TLO];
      end
      if (bus_err_clr) begin
         err_nxt = 1'b0;
      end

      unique case (state_r)
         s_idle: begin
            if (take) begin
               if (fn == `DECD_FN_PFIX) begin
                  oreg_nxt = oper << 4;
               end else if (fn == `DECD_FN_NFIX) begin
                  oreg_nxt = (~oper) << 4;
               end else if (acc_ours) begin
                  oreg_nxt  = '0;
                  op_nxt    = oper;
                  j0_nxt    = is_j0;
                  cost_nxt  = acc_cost;
                  cnt_nxt   = acc_cost - CW'(1);
                  pend_nxt  = acc_pend;
                  fail_nxt  = acc_fail;
                  state_nxt = s_exec;
                  ready_nxt = 1'b0;
               end else begin
                  // Not executed here: the built operand goes back out.
                  oreg_nxt   = '0;
                  result_nxt = oper;
                  other_nxt  = 1'b1;
               end
            end
         end
         s_exec: begin
            if (cnt_r != '0) begin
               cnt_nxt = cnt_r - CW'(1);
            end else begin
               state_nxt = s_idle;
               ready_nxt = 1'b1;
               done_nxt  = 1'b1;
               if (j0_r) begin
                  if (brk_r) begin
                     break_nxt = 1'b1;
                  end else begin
                     desched_nxt = i_slice_due;
                  end
               end else begin
                  unique case (op_r)
                     `DECD_OP_TESTERR: begin
                        result_nxt = W'(~err_r);
                        wr_nxt     = 1'b1;
                        err_nxt    = 1'b0;
                     end
                     `DECD_OP_STOPERR: desched_nxt = err_r;
                     `DECD_OP_ZERO_BASED_INDEX_CHECK, `DECD_OP_ONE_BASED_COUNT_CHECK: begin
                        result_nxt = pend_r;
                        wr_nxt     = 1'b1;
                     end
                     `DECD_OP_BREAK:   break_nxt = 1'b1;
                     `DECD_OP_CLRBRK:  brk_nxt   = 1'b0;
                     `DECD_OP_SETBRK:  brk_nxt   = 1'b1;
                     `DECD_OP_TESTBRK: begin
                        result_nxt = W'(brk_r);
                        wr_nxt     = 1'b1;
                     end
                     `DECD_OP_TDISH:   thi_nxt = 1'b0;
                     `DECD_OP_TDISL:   tlo_nxt = 1'b0;
                     `DECD_OP_TENH:    thi_nxt = 1'b1;
                     `DECD_OP_TENL:    tlo_nxt = 1'b1;
                     `DECD_OP_CRCW, `DECD_OP_CRCB, `DECD_OP_BITCNT,
                     `DECD_OP_REVW, `DECD_OP_REVN: begin
                        result_nxt = pend_r;
                        wr_nxt     = 1'b1;
                     end
                     default: ;
                  endcase
                  // A range fault or an explicit set beats any clear.
                  if ((fail_r && ((op_r == `DECD_OP_ZERO_BASED_INDEX_CHECK) ||
                                  (op_r == `DECD_OP_ONE_BASED_COUNT_CHECK))) ||
                      (op_r == `DECD_OP_SETERR)) begin
                     err_nxt = 1'b1;
                  end
               end
            end
         end
      endcase
   end

   // ============================================================
   // Registers. The clock enable freezes every flop, pulses included.
   always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
         state_r   <= s_idle;
         oreg_r    <= '0;
         op_r      <= '0;
         j0_r      <= 1'b0;
         cnt_r     <= '0;
         cost_r    <= '0;
         pend_r    <= '0;
         fail_r    <= 1'b0;
         ready_r   <= 1'b1;
         done_r    <= 1'b0;
         result_r  <= '0;
         wr_r      <= 1'b0;
         other_r   <= 1'b0;
         desched_r <= 1'b0;
         break_r   <= 1'b0;
         err_r     <= `DECD_RST_ERR;
         brk_r     <= `DECD_RST_BRK;
         thi_r     <= `DECD_RST_THI;
         tlo_r     <= `DECD_RST_TLO;
         rdata_r   <= '0;
      end else if (i_ce) begin
         state_r   <= state_nxt;
         oreg_r    <= oreg_nxt;
         op_r      <= op_nxt;
         j0_r      <= j0_nxt;
         cnt_r     <= cnt_nxt;
         cost_r    <= cost_nxt;
         pend_r    <= pend_nxt;
         fail_r    <= fail_nxt;
         ready_r   <= ready_nxt;
         done_r    <= done_nxt;
         result_r  <= result_nxt;
         wr_r      <= wr_nxt;
         other_r   <= other_nxt;
         desched_r <= desched_nxt;
         break_r   <= break_nxt;
         err_r     <= err_nxt;
         brk_r     <= brk_nxt;
         thi_r     <= thi_nxt;
         tlo_r     <= tlo_nxt;
         rdata_r   <= rdata_nxt;
      end
   end

   // ============================================================
   // Outputs, each straight from a flop.
   assign o_ready       = ready_r;
   assign o_done        = done_r;
   assign o_result      = result_r;
   assign o_result_wr   = wr_r;
   assign o_other       = other_r;
   assign o_desched     = desched_r;
   assign o_break       = break_r;
   assign o_error       = err_r;
   assign o_brk_en      = brk_r;
   assign o_timer_hi_en = thi_r;
   assign o_timer_lo_en = tlo_r;
   assign o_rdata       = rdata_r;

endmodule // decd_core

/* hw/decd_crc.sv */
`timescale 1ns/100ps
`include "decd_regs.svh"

module decd_crc #(
   parameter int W = 16
) (
   input  wire logic [W-1:0] i_data,
   input  wire logic [W-1:0] i_crc,
   input  wire logic [W-1:0] i_poly,
   output logic      [W-1:0] o_crc_word,
   output logic      [W-1:0] o_crc_byte
);

   // ============================================================
   // One CRC step per data bit, most significant bit first.
   function automatic logic [W-1:0] crc_steps(input logic [W-1:0] crc,
                                              input logic [W-1:0] data,
                                              input logic [W-1:0] poly,
                                              input int           nbits);
      logic [W-1:0] c;
      logic         msb;
      c = crc;
      for (int i = 0; i < W; i++) begin
         if (i < nbits) begin
            msb = c[W-1];
            c   = {c[W-2:0], data[W-1-i]};
            if (msb) begin
               c = c ^ poly;
            end
         end
      end
      return c;
   endfunction

   // The byte form consumes the top byte of the data word.
   assign o_crc_word = crc_steps(i_crc, i_data, i_poly, W);
   assign o_crc_byte = crc_steps(i_crc, i_data, i_poly, 8);

endmodule // decd_crc

/* hw/decd_pkg.sv */
package decd_pkg;

   // ============================================================
   // Sequencer states.
   typedef enum logic {
      s_idle,
      s_exec
   } decd_state_t;

endpackage

/* hw/decd_regs.svh */
`ifndef DECD_REGS_SVH
`define DECD_REGS_SVH

// ============================================================
// Register map of the plain software port.
`define DECD_ADDR_CTRL      2'h0
`define DECD_ADDR_STAT      2'h1
`define DECD_ADDR_LAST      2'h2
`define DECD_ADDR_COST      2'h3

`define DECD_CTRL_BRK       0
`define DECD_CTRL_THI       1
`define DECD_CTRL_TLO       2
`define DECD_STAT_ERR       0
`define DECD_STAT_BUSY      1

`define DECD_RST_BRK        1'h0
`define DECD_RST_THI        1'h1
`define DECD_RST_TLO        1'h1
`define DECD_RST_ERR        1'h0

// ============================================================
// Instruction byte function codes.
`define DECD_FN_JUMP        4'h0
`define DECD_FN_PFIX        4'h2
`define DECD_FN_NFIX        4'h6
`define DECD_FN_OPR         4'hF

// ============================================================
// Operation codes handled by this block.
`define DECD_OP_ZERO_BASED_INDEX_CHECK       16'h0013
`define DECD_OP_SETERR      16'h0010
`define DECD_OP_TESTERR     16'h0029
`define DECD_OP_ONE_BASED_COUNT_CHECK       16'h004D
`define DECD_OP_STOPERR     16'h0055
`define DECD_OP_CRCW        16'h0074
`define DECD_OP_CRCB        16'h0075
`define DECD_OP_BITCNT      16'h0076
`define DECD_OP_REVW        16'h0077
`define DECD_OP_REVN        16'h0078
`define DECD_OP_TDISH       16'h007A
`define DECD_OP_TDISL       16'h007B
`define DECD_OP_TENH        16'h007C
`define DECD_OP_TENL        16'h007D
`define DECD_OP_BREAK       16'h00B1
`define DECD_OP_CLRBRK      16'h00B2
`define DECD_OP_SETBRK      16'h00B3
`define DECD_OP_TESTBRK     16'h00B4

// ============================================================
// Execution costs in core clock cycles.
`define DECD_C_TESTERR_OK   17'h00002
`define DECD_C_TESTERR_ERR  17'h00003
`define DECD_C_STOPERR      17'h00002
`define DECD_C_ZERO_BASED_INDEX_CHECK        17'h00002
`define DECD_C_ONE_BASED_COUNT_CHECK        17'h00003
`define DECD_C_SETERR       17'h00001
`define DECD_C_J0           17'h00003
`define DECD_C_J0_BRK_HI    17'h0000B
`define DECD_C_J0_BRK_LO    17'h0000D
`define DECD_C_BREAK_HI     17'h00009
`define DECD_C_BREAK_LO     17'h0000B
`define DECD_C_BRKFLAG      17'h00001
`define DECD_C_TESTBRK      17'h00002
`define DECD_C_TDIS         17'h00001
`define DECD_C_TEN          17'h00006
`define DECD_C_CRCW         17'h00023
`define DECD_C_CRCB         17'h0000B
`define DECD_C_BITCNT_ADD   17'h00002
`define DECD_C_REVW         17'h00024
`define DECD_C_REVN_ADD     17'h00004

`endif

/* verification/decd_core_props.sv */
`timescale 1ns/100ps
module decd_core_props (
   input wire logic        i_clk,
   input wire logic        i_rstn,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic        o_ready,
   input wire logic        o_done,
   input wire logic        o_result_wr,
   input wire logic        o_desched,
   input wire logic        o_break,
   input wire logic        o_brk_en,
   input wire logic        o_timer_hi_en,
   input wire logic        o_timer_lo_en,
   input wire logic [15:0] o_rdata
);
   // ============================================================
   // Timing relations of the instruction side and of the software port.
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rstn);
   a_done_ready: assert property (o_done |-> o_ready)
      else $error("done without ready");
   a_wr_done: assert property (o_result_wr |-> o_done)
      else $error("result push outside done");
   a_desched_done: assert property (o_desched |-> o_done)
      else $error("deschedule outside done");
   a_break_clean: assert property (o_break |-> o_done && !o_desched)
      else $error("break with deschedule");
   a_break_len: assert property (o_break |-> !$past(o_ready) && !$past(o_ready, 9))
      else $error("break too short");
   a_brk_cause: assert property ($changed(o_brk_en) |-> o_done || $past(i_wr))
      else $error("break flag changed alone");
   a_timer_cause: assert property (($changed(o_timer_hi_en) || $changed(o_timer_lo_en))
      |-> o_done || $past(i_wr))
      else $error("timer enable changed alone");
   // Longest operation used by the bench is 36 cycles, so 40 bounds every run.
   a_op_bound: assert property ($fell(o_ready) |-> ##[1:40] o_done)
      else $error("operation never finished");
   a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
      else $error("read data outside read");
   c_break: cover property (o_break);
   c_desched: cover property (o_desched);
   c_push: cover property (o_result_wr);
endmodule // decd_core_props

bind decd_core decd_core_props u_props (.i_clk, .i_rstn, .i_wr, .i_rd, .o_ready, .o_done,
   .o_result_wr, .o_desched, .o_break, .o_brk_en, .o_timer_hi_en, .o_timer_lo_en, .o_rdata);

/* verification/decd_fetch_model.sv */
`timescale 1ns/100ps
module decd_fetch_model (
   input  wire logic       i_clk,
   input  wire logic       i_ready,
   output logic            o_valid,
   output logic      [7:0] o_byte
);
   // ============================================================
   // Byte queue of the program stream.
   logic [7:0] q[$];
   logic [7:0] last = 8'h00;
   bit         slow = 1'b0;
   bit         gap  = 1'b0;
   initial begin
      o_valid = 1'b0;
      o_byte  = 8'hFF;
   end
   task put(input logic [7:0] b);
      q.push_back(b);
   endtask
   // A byte not yet taken is held; an idle line shows the inverse so stale data never match.
   always @(posedge i_clk) begin
      if (!(o_valid && !i_ready)) begin
         if (o_valid) last = q.pop_front();
         gap = slow && !gap;
         o_valid <= q.size() != 0 && !gap;
         o_byte  <= (q.size() != 0 && !gap) ? q[0] : ~last;
      end
   end
endmodule // decd_fetch_model

/* verification/tb_decd_core.sv */
`timescale 1ns/100ps
module tb_decd_core;
   logic        i_clk, i_rstn, i_ce, i_instr_valid, i_high_pri, i_slice_due, i_wr, i_rd;
   logic [7:0]  i_instr_byte;
   logic [15:0] i_areg, i_breg, i_creg, i_wdata, o_result, o_rdata, lf, cyc, res, rd_v, a, b;
   logic [1:0]  i_addr;
   logic        o_ready, o_done, o_result_wr, o_other, o_desched, o_break, o_error;
   logic        o_brk_en, o_timer_hi_en, o_timer_lo_en;
   int          failures, total_checks, n;

   decd_core uut (.i_clk, .i_rstn, .i_ce, .i_instr_valid, .i_instr_byte, .i_areg, .i_breg,
      .i_creg, .i_high_pri, .i_slice_due, .i_addr, .i_wdata, .i_wr, .i_rd, .o_ready, .o_done,
      .o_result, .o_result_wr, .o_other, .o_desched, .o_break, .o_error, .o_brk_en,
      .o_timer_hi_en, .o_timer_lo_en, .o_rdata);
   decd_fetch_model fm (.i_clk, .i_ready(o_ready), .o_valid(i_instr_valid), .o_byte(i_instr_byte));

   initial begin
      i_clk = 1'b0;
      forever #2 i_clk = ~i_clk;
   end

   // ============================================================
   // Reference functions and tasks.
   function logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function logic [15:0] rev(input logic [15:0] v);
      for (int i = 0; i < 16; i++) rev[i] = v[15-i];
   endfunction
   function logic [15:0] pop(input logic [15:0] v);
      pop = 16'h0;
      for (int i = 0; i < 16; i++) pop = pop + 16'(v[i]);
   endfunction
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task test_done;
      $display("checks=%0d failures=%0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Cost is counted as ready-low cycles; returns in the done cycle, so pulses are still up.
   task op(input logic [15:0] code, input bit jz);
      int k;
      cyc = 16'h0;
      k = 0;
      if (jz) fm.put(8'h00);
      else begin
         if (code[7:4] != 4'h0) fm.put({4'h2, code[7:4]});
         fm.put({4'hF, code[3:0]});
      end
      do begin
         @(posedge i_clk);
         #1;
         if (o_ready === 1'b0) cyc++;
         k++;
      end while (o_done !== 1'b1 && k < 300);
      if (k >= 300) begin
         failures++;
         test_done;
      end
      res = o_result;
   endtask
   task wr(input logic [1:0] ad, input logic [15:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1; i_addr <= ad; i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask
   task rd(input logic [1:0] ad);
      @(posedge i_clk);
      i_rd <= 1'b1; i_addr <= ad;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 rd_v = o_rdata;
   endtask

   // ============================================================
   // Main sequence.
   initial begin
      {i_rstn, i_high_pri, i_slice_due, i_wr, i_rd, i_addr} = 6'h00;
      {i_areg, i_breg, i_creg, i_wdata} = 64'h0;
      i_ce = 1'b1;
      failures = 0; total_checks = 0; lf = 16'hE45C;
      repeat (2) @(posedge i_clk);
      i_rstn <= 1'b1;
      @(posedge i_clk);
      #1 chk({11'h0, o_ready, o_error, o_brk_en, o_timer_hi_en, o_timer_lo_en}, 16'h0013);
      i_areg <= 16'h4; i_breg <= 16'h4;
      op(16'h0013, 0); chk(cyc, 16'h2); chk(o_error, 16'h1);
      op(16'h0029, 0); chk(cyc, 16'h3); chk(res[0], 16'h0); chk(o_error, 16'h0);
      op(16'h0029, 0); chk(cyc, 16'h2); chk(res[0], 16'h1);
      i_breg <= 16'h3;
      op(16'h0013, 0); chk(cyc, 16'h2); chk(o_error, 16'h0);
      op(16'h0055, 0); chk(cyc, 16'h2); chk(o_desched, 16'h0);
      i_breg <= 16'hFFFF;
      op(16'h0013, 0); op(16'h0055, 0); chk(o_desched, 16'h1);
      wr(2'h1, 16'h1); rd(2'h1); chk(rd_v, 16'h0);
      $display("error tests done");
      i_slice_due <= 1'b1;
      op(16'h0, 1); chk(cyc, 16'h3); chk({o_desched, o_break}, 16'h2);
      op(16'h00B3, 0); chk(cyc, 16'h1); chk(o_brk_en, 16'h1);
      op(16'h00B4, 0); chk(cyc, 16'h2); chk(res, 16'h1);
      i_high_pri <= 1'b1;
      op(16'h0, 1); chk(cyc, 16'hB); chk({o_desched, o_break}, 16'h1);
      i_high_pri <= 1'b0;
      op(16'h0, 1); chk(cyc, 16'hD); chk({o_desched, o_break}, 16'h1);
      op(16'h00B2, 0); chk(cyc, 16'h1); chk(o_brk_en, 16'h0);
      op(16'h00B4, 0); chk(res, 16'h0);
      for (n = 0; n < 4; n++) begin
         op(16'h007A + 16'(n), 0); chk(cyc, (n < 2) ? 16'h1 : 16'h6);
         chk({14'h0, o_timer_hi_en, o_timer_lo_en}, (16'h3201 >> (4 * n)) & 16'hF);
      end
      wr(2'h0, 16'h5); rd(2'h0); chk(rd_v, 16'h5); chk(o_brk_en, 16'h1);
      wr(2'h0, 16'h6);
      $display("breakpoint and timer tests done");
      fm.slow = 1'b1;
      for (n = 0; n < 25; n++) begin
         lf = lfsr(lf); a = (n % 5 == 4) ? 16'(n & 15) : lf;
         lf = lfsr(lf); b = lf;
         i_areg <= a; i_breg <= b; i_creg <= lfsr(lf);
         case (n % 5)
            0: begin op(16'h0074, 0); chk(cyc, 16'h23); end
            1: begin op(16'h0075, 0); chk(cyc, 16'hB); end
            2: begin op(16'h0076, 0); chk(cyc, pop(a) + 16'h2); chk(res, pop(a)); end
            3: begin op(16'h0077, 0); chk(cyc, 16'h24); chk(res, rev(a)); end
            default: begin op(16'h0078, 0); chk(cyc, a + 16'h4); chk(res, rev(b) >> (16 - a)); end
         endcase
      end
      rd(2'h2); chk(rd_v, 16'h0078);
      rd(2'h3); chk(rd_v, a + 16'h4);
      $display("arithmetic tests done");
      test_done;
   end
endmodule // tb_decd_core
